// *** ohp_pkg.sv ***
/*
 * Shared constants and state types for the OLED host port and frame memory block.
 * Assumes a single system clock of 40 MHz; the link side runs on the host's serial clock.
 */
package ohp_pkg;

   // Frame memory geometry, queued word width and queue depth.
   localparam int FRAME_COLS = 128;
   localparam int FRAME_ROWS = 39;
   localparam int FRAME_PAGES = 5;
   localparam int PAGE_ROWS = 8;
   localparam int LAST_PAGE = 4;
   localparam int WORD_W = 9;
   localparam int FIFO_DEPTH = 16;

   // Command codes.
   localparam logic [7:0] CMD_DISP_ON = 8'hAF;
   localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
   localparam logic [7:0] CMD_SEG_NORM = 8'hA0;
   localparam logic [7:0] CMD_SEG_REV = 8'hA1;
   localparam logic [7:0] CMD_SCAN_NORM = 8'hC0;
   localparam logic [7:0] CMD_SCAN_REV = 8'hC8;
   localparam logic [7:0] CMD_START_LINE = 8'hD3;
   localparam logic [3:0] CMD_COL_LOW_HI = 4'h0;
   localparam logic [4:0] CMD_COL_HIGH_HI = 5'h02;
   localparam logic [4:0] CMD_PAGE_HI = 5'h16;

   // I2C control byte fields and address base (address base value is arbitrary).
   localparam int CTRL_CO_BIT = 7;
   localparam int CTRL_DC_BIT = 6;
   localparam logic [5:0] I2C_ADDR_BASE = 6'h1E;

   // Reset values of the display configuration.
   localparam logic SEG_REV_RST = 1'b0;
   localparam logic SCAN_REV_RST = 1'b0;
   localparam logic [5:0] START_LINE_RST = 6'h00;

   // Driver turn-on delay after the display-on command.
   localparam longint CLK_HZ = 40_000_000;
   localparam longint T_DRV_ON_MS = 100;
   localparam int DRV_ON_CYCLES = int'(CLK_HZ * T_DRV_ON_MS / 1000);
   localparam int DRV_CNT_W = 23;

   typedef enum logic [2:0] {
      I2C_IDLE,
      I2C_ADDR,
      I2C_CTRL,
      I2C_DATA
   } ohp_i2c_state_t;

   // Link-domain state of the serial shifter.
   typedef struct packed {
      logic [6:0] shift;
      logic [2:0] count;
      logic [8:0] word;
      logic toggle;
   } ohp_link_t;

   // System-domain state.
   typedef struct packed {
      ohp_i2c_state_t i2c_st;
      logic scl_p;
      logic sda_p;
      logic [3:0] bits;
      logic [7:0] i2c_shift;
      logic ctrl_co;
      logic ctrl_dc;
      logic ack_oe;
      logic tog_p;
      logic overrun;
      logic seg_rev;
      logic scan_rev;
      logic [5:0] start_line;
      logic want_start;
      logic [6:0] col;
      logic [2:0] page;
      logic disp_cmd_on;
      logic drv_on;
      logic [DRV_CNT_W-1:0] on_cnt;
      logic [FRAME_COLS-1:0] col_out;
      logic [FRAME_PAGES-1:0][FRAME_COLS-1:0][PAGE_ROWS-1:0] mem;
   } ohp_sys_t;

endpackage

// *** ohp_sync2.sv ***
/*
 * Two-flop synchroniser for a bus of independent levels.
 * Assumes each bit is a level or a toggle that stays put for several destination clocks.
 */
`timescale 1ns/1ps
module ohp_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } ohp_sync_t;

   ohp_sync_t st_q;
   ohp_sync_t st_d;

   // The first stage feeds only the second stage.
   always_comb begin
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   // Both stages clear to zero under reset.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;
endmodule // ohp_sync2

// *** ohp_fifo.sv ***
/*
 * Synchronous FIFO in flip-flops with valid and ready on both sides.
 * Assumes both sides run on the same clock; depth must be a power of two.
 */
`timescale 1ns/1ps
module ohp_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] store;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] used;
   } ohp_fifo_t;

   ohp_fifo_t st_q;
   ohp_fifo_t st_d;
   logic do_push;
   logic do_pop;

   // Refuse at elaboration a depth that the pointers cannot wrap cleanly.
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("FIFO depth must be a power of two of at least two.");
   end

   // Full and empty come straight from the fill count.
   assign in_ready = (st_q.used != (AW + 1)'(DEPTH));
   assign out_valid = (st_q.used != '0);
   assign out_data = st_q.store[st_q.rd];
   assign do_push = in_valid && in_ready;
   assign do_pop = out_valid && out_ready;

   // Pointer and count update; simultaneous push and pop keep the count.
   always_comb begin
      st_d = st_q;
      if (do_push) begin
         st_d.store[st_q.wr] = in_data;
         st_d.wr = st_q.wr + 1'b1;
      end
      if (do_pop) begin
         st_d.rd = st_q.rd + 1'b1;
      end
      if (do_push && !do_pop) begin
         st_d.used = st_q.used + 1'b1;
      end else if (do_pop && !do_push) begin
         st_d.used = st_q.used - 1'b1;
      end
   end

   // Register the whole state.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule // ohp_fifo

// *** ohp_host_port.sv ***
/*
 * Host port, command decoder and frame memory of a monochrome OLED controller.
 * Assumes the host drives the serial clock, the refresh logic on CLK_SYS drives the row index,
 * and NRST is the hardware init line already held low long enough by the host.
 */
// Notes on behaviour
// RULE1: Port select low picks four-wire serial, high picks I2C.
// RULE2: In serial mode the flag pin marks each byte command or data.
// RULE3: In I2C mode the flag pin picks the low slave address bit.
// RULE4: Clock pin, data-in pin and data-out pin change roles with the selected port.
// RULE5: Host holds init line low at least 3 us before any command.
// RULE6: Display-on command turns the drivers on 100 ms later.
// RULE7: Host sends display-off and waits for discharge before removing panel supply.
// RULE8: Frame memory is 128 columns by 39 rows in five pages of eight.
// RULE9: A data byte fills the whole 8-bit column at the pointer in the page.
// RULE10: Bit 0 is the top row, bit 7 the bottom; page four drops bit 7.
// RULE11: A0 maps column 0 to output 0; A1 reverses to output 127.
// RULE12: C0 maps row 0 to output 0; C8 reverses to output 38.
// RULE13: Start line set by D3 picks which memory row is shown first.
// RULE14: Serial flag low means command, high means data, sampled with last bit.
`timescale 1ns/1ps
module ohp_host_port
   import ohp_pkg::*;
#(
   parameter int ON_DELAY_CYCLES = ohp_pkg::DRV_ON_CYCLES,
   parameter logic [5:0] ADDR_BASE = ohp_pkg::I2C_ADDR_BASE
) (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic CLOCK_LINE_PIN,
   input wire logic HOST_PORT_SELECT,
   input wire logic CMD_OR_PAYLOAD_FLAG,
   input wire logic CHIP_SELECT_N,
   input wire logic SERIAL_DATA_IN,
   output logic I2C_OUT_LINE_O,
   output logic I2C_OUT_LINE_OE,
   input wire logic FRAME_MEM_HOLD,
   input wire logic [5:0] ROW_DRIVER_INDEX,
   output logic [ohp_pkg::FRAME_COLS-1:0] COLUMN_DRIVER_OUTPUT,
   output logic DRIVERS_ON,
   output logic SERIAL_OVERRUN
);
   import ohp_pkg::*;

   ohp_link_t lk_q;
   ohp_link_t lk_d;
   ohp_sys_t st_q;
   ohp_sys_t st_d;
   logic [3:0] pins_s;
   logic tog_s;
   logic scl_s;
   logic sda_s;
   logic strap_s;
   logic i2c_mode;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic [WORD_W-1:0] fifo_in_data;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [WORD_W-1:0] fifo_out_data;

   // Refuse at elaboration a delay that the turn-on counter cannot hold.
   if (ON_DELAY_CYCLES < 1 || ON_DELAY_CYCLES >= (1 << DRV_CNT_W)) begin : g_bad_delay
      $error("Driver turn-on delay does not fit its counter.");
   end

   // Serial shifter on the host clock; the flag is taken with the eighth bit.
   always_comb begin
      lk_d = lk_q;
      if (!CHIP_SELECT_N) begin
         lk_d.shift = {lk_q.shift[5:0], SERIAL_DATA_IN}; // RULE4
         lk_d.count = lk_q.count + 1'b1;
         if (lk_q.count == 3'd7) begin
            lk_d.word = {CMD_OR_PAYLOAD_FLAG, lk_q.shift, SERIAL_DATA_IN}; // RULE2 RULE14
            lk_d.toggle = ~lk_q.toggle;
         end
      end
   end

   // Link-domain state register.
   always_ff @(posedge CLOCK_LINE_PIN or negedge NRST) begin
      if (!NRST) begin
         lk_q <= '0;
      end else begin
         lk_q <= lk_d;
      end
   end

   // Pin levels and the byte toggle cross into the system domain.
   ohp_sync2 #(
      .WIDTH(4)
   ) u_pin_sync (
      .clk(CLK_SYS),
      .rst_n(NRST),
      .d({CLOCK_LINE_PIN, SERIAL_DATA_IN, CMD_OR_PAYLOAD_FLAG, HOST_PORT_SELECT}),
      .q(pins_s)
   );

   ohp_sync2 #(
      .WIDTH(1)
   ) u_tog_sync (
      .clk(CLK_SYS),
      .rst_n(NRST),
      .d(lk_q.toggle),
      .q(tog_s)
   );

   assign scl_s = pins_s[3];
   assign sda_s = pins_s[2];
   assign strap_s = pins_s[1];
   assign i2c_mode = pins_s[0]; // RULE1

   // Byte queue between the host port and the decoder.
   ohp_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK_SYS),
      .rst_n(NRST),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data)
   );

   // The decoder pauses while the refresh logic holds the memory.
   assign fifo_out_ready = ~FRAME_MEM_HOLD;

   // I2C slave, serial capture, command decoder, driver delay and scan output.
   always_comb begin
      logic rise;
      logic fall;
      logic start;
      logic stop;
      logic [7:0] b;
      logic [5:0] lrow;
      logic [6:0] mrow;
      logic [6:0] csel;
      st_d = st_q;
      rise = scl_s && !st_q.scl_p;
      fall = !scl_s && st_q.scl_p;
      start = scl_s && st_q.scl_p && st_q.sda_p && !sda_s;
      stop = scl_s && st_q.scl_p && !st_q.sda_p && sda_s;
      b = fifo_out_data[7:0];
      lrow = '0;
      mrow = '0;
      csel = '0;
      fifo_in_valid = 1'b0;
      fifo_in_data = '0;
      st_d.scl_p = scl_s;
      st_d.sda_p = sda_s;
      st_d.tog_p = tog_s;

      // A completed serial byte is queued unless I2C is selected; a full queue drops it and flags overrun.
      if (tog_s != st_q.tog_p && !i2c_mode) begin
         fifo_in_valid = 1'b1;
         fifo_in_data = lk_q.word;
         if (!fifo_in_ready) begin
            st_d.overrun = 1'b1;
         end
      end

      // I2C receive: bits on SCL rise, acknowledge driven from SCL fall to the next fall.
      if (!i2c_mode) begin
         st_d.i2c_st = I2C_IDLE;
         st_d.ack_oe = 1'b0;
      end else if (start) begin
         st_d.i2c_st = I2C_ADDR;
         st_d.bits = '0;
         st_d.ack_oe = 1'b0;
      end else if (stop) begin
         st_d.i2c_st = I2C_IDLE;
         st_d.ack_oe = 1'b0;
      end else if (st_q.i2c_st != I2C_IDLE) begin
         if (rise && st_q.bits != 4'd8 && !st_q.ack_oe) begin // The acknowledge clock shifts nothing.
            st_d.i2c_shift = {st_q.i2c_shift[6:0], sda_s}; // RULE4
            st_d.bits = st_q.bits + 1'b1;
         end
         if (fall && st_q.ack_oe) begin
            st_d.ack_oe = 1'b0;
         end else if (fall && st_q.bits == 4'd8) begin
            st_d.bits = '0;
            case (st_q.i2c_st)
               I2C_ADDR: begin
                  if (st_q.i2c_shift == {ADDR_BASE, strap_s, 1'b0}) begin // RULE3
                     st_d.ack_oe = 1'b1;
                     st_d.i2c_st = I2C_CTRL;
                  end else begin
                     st_d.i2c_st = I2C_IDLE;
                  end
               end
               I2C_CTRL: begin
                  st_d.ctrl_co = st_q.i2c_shift[CTRL_CO_BIT];
                  st_d.ctrl_dc = st_q.i2c_shift[CTRL_DC_BIT];
                  st_d.ack_oe = 1'b1;
                  st_d.i2c_st = I2C_DATA;
               end
               I2C_DATA: begin
                  fifo_in_valid = 1'b1;
                  fifo_in_data = {st_q.ctrl_dc, st_q.i2c_shift};
                  if (fifo_in_ready) begin
                     st_d.ack_oe = 1'b1;
                     st_d.i2c_st = st_q.ctrl_co ? I2C_CTRL : I2C_DATA;
                  end else begin
                     st_d.i2c_st = I2C_IDLE;
                  end
               end
               default: begin
                  st_d.i2c_st = I2C_IDLE;
               end
            endcase
         end
      end

      // Decoder: data bytes fill a column, commands update configuration.
      if (fifo_out_valid && fifo_out_ready) begin
         if (fifo_out_data[8]) begin
            st_d.mem[st_q.page][st_q.col] = b; // RULE9 RULE10
            if (st_q.page == 3'(LAST_PAGE)) begin
               st_d.mem[st_q.page][st_q.col][PAGE_ROWS-1] = 1'b0; // RULE10
            end
            st_d.col = st_q.col + 1'b1;
         end else if (st_q.want_start) begin
            st_d.want_start = 1'b0;
            st_d.start_line = (b[5:0] < 6'(FRAME_ROWS)) ? b[5:0] : b[5:0] - 6'(FRAME_ROWS); // RULE13
         end else if (b == CMD_DISP_ON) begin
            st_d.disp_cmd_on = 1'b1; // RULE6
            st_d.on_cnt = '0;
         end else if (b == CMD_DISP_OFF) begin
            st_d.disp_cmd_on = 1'b0;
            st_d.drv_on = 1'b0;
         end else if (b == CMD_SEG_NORM || b == CMD_SEG_REV) begin
            st_d.seg_rev = b[0]; // RULE11
         end else if (b == CMD_SCAN_NORM || b == CMD_SCAN_REV) begin
            st_d.scan_rev = b[3]; // RULE12
         end else if (b == CMD_START_LINE) begin
            st_d.want_start = 1'b1; // RULE13
         end else if (b[7:4] == CMD_COL_LOW_HI) begin
            st_d.col[3:0] = b[3:0];
         end else if (b[7:3] == CMD_COL_HIGH_HI) begin
            st_d.col[6:4] = b[2:0];
         end else if (b[7:3] == CMD_PAGE_HI && b[2:0] <= 3'(LAST_PAGE)) begin
            st_d.page = b[2:0];
         end
      end

      // Drivers come on once the delay after display-on has run out.
      if (st_q.disp_cmd_on && !st_q.drv_on) begin
         st_d.on_cnt = st_q.on_cnt + 1'b1;
         if (st_q.on_cnt == DRV_CNT_W'(ON_DELAY_CYCLES - 1)) begin
            st_d.drv_on = 1'b1; // RULE6
         end
      end

      // Scan output for the requested driver row, with remap and start line applied.
      st_d.col_out = '0;
      if (st_q.drv_on && ROW_DRIVER_INDEX < 6'(FRAME_ROWS)) begin
         lrow = st_q.scan_rev ? 6'(FRAME_ROWS - 1) - ROW_DRIVER_INDEX : ROW_DRIVER_INDEX; // RULE12
         mrow = {1'b0, lrow} + {1'b0, st_q.start_line}; // RULE13
         if (mrow >= 7'(FRAME_ROWS)) begin
            mrow = mrow - 7'(FRAME_ROWS);
         end
         for (int j = 0; j < FRAME_COLS; j++) begin
            csel = st_q.seg_rev ? 7'(FRAME_COLS - 1 - j) : 7'(j); // RULE11
            st_d.col_out[j] = st_q.mem[mrow[5:3]][csel][mrow[2:0]]; // RULE8 RULE10
         end
      end

      // Overrun is sticky and survives everything but reset.
      st_d.overrun = st_d.overrun | st_q.overrun;
   end

   // System-domain state register; reset restores the default mappings.
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         st_q <= '0;
         st_q.seg_rev <= SEG_REV_RST;
         st_q.scan_rev <= SCAN_REV_RST;
         st_q.start_line <= START_LINE_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // The data-out line only ever pulls low, so its output bit is a constant-zero flop.
   logic sda_o_q;
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         sda_o_q <= 1'b0;
      end else begin
         sda_o_q <= 1'b0;
      end
   end

   assign I2C_OUT_LINE_O = sda_o_q;
   assign I2C_OUT_LINE_OE = st_q.ack_oe; // RULE4
   assign COLUMN_DRIVER_OUTPUT = st_q.col_out;
   assign DRIVERS_ON = st_q.drv_on;
   assign SERIAL_OVERRUN = st_q.overrun;
endmodule // ohp_host_port

// *** ohp_host_port_sva.sv ***
/*
 * Port-level checker for the OLED host port and frame memory block.
 * Assumes it is bound to every ohp_host_port instance and sees only its ports.
 */
`timescale 1ns/1ps
module ohp_host_port_sva #(
   parameter int ON_DELAY_CYCLES = 20
) (
   input wire logic CLK_SYS,
   input wire logic NRST,
   input wire logic CLOCK_LINE_PIN,
   input wire logic HOST_PORT_SELECT,
   input wire logic CMD_OR_PAYLOAD_FLAG,
   input wire logic CHIP_SELECT_N,
   input wire logic SERIAL_DATA_IN,
   input wire logic I2C_OUT_LINE_O,
   input wire logic I2C_OUT_LINE_OE,
   input wire logic FRAME_MEM_HOLD,
   input wire logic [5:0] ROW_DRIVER_INDEX,
   input wire logic [ohp_pkg::FRAME_COLS-1:0] COLUMN_DRIVER_OUTPUT,
   input wire logic DRIVERS_ON,
   input wire logic SERIAL_OVERRUN
);
   import ohp_pkg::*;
   int off_cnt_q;
   // All checks run on the system clock and pause while reset is low.
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!NRST);
   // Counts cycles with the drivers off, saturating at the turn-on delay.
   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) off_cnt_q <= 0;
      else if (DRIVERS_ON) off_cnt_q <= 0;
      else if (off_cnt_q < ON_DELAY_CYCLES) off_cnt_q <= off_cnt_q + 1;
   end
   // Drivers off for two cycles, and the decoder held for three.
   sequence s_off2;
      !DRIVERS_ON ##1 !DRIVERS_ON;
   endsequence
   sequence s_held;
      FRAME_MEM_HOLD [*3];
   endsequence
   reset_quiet_a: assert property ($rose(NRST) |-> !DRIVERS_ON && !SERIAL_OVERRUN && !I2C_OUT_LINE_OE)
      else $error("outputs not quiet after reset");
   out_level_a: assert property (I2C_OUT_LINE_O == 1'b0)
      else $error("data-out line not low");
   serial_no_ack_a: assert property (!HOST_PORT_SELECT [*4] |-> !I2C_OUT_LINE_OE)
      else $error("acknowledge driven in serial mode");
   overrun_sticky_a: assert property (SERIAL_OVERRUN |=> SERIAL_OVERRUN)
      else $error("overrun flag cleared without reset");
   overrun_cause_a: assert property ($rose(SERIAL_OVERRUN) |-> $past(FRAME_MEM_HOLD, 2))
      else $error("overrun without a stalled decoder");
   blank_off_a: assert property (s_off2 |-> COLUMN_DRIVER_OUTPUT == '0)
      else $error("columns driven while drivers off");
   blank_range_a: assert property (ROW_DRIVER_INDEX > 6'h26 |=> COLUMN_DRIVER_OUTPUT == '0)
      else $error("columns driven for a row past the last");
   hold_freeze_a: assert property (s_held |-> !$fell(DRIVERS_ON))
      else $error("drivers turned off while decoder held");
   on_delay_a: assert property ($rose(DRIVERS_ON) |-> off_cnt_q >= ON_DELAY_CYCLES)
      else $error("drivers on before the turn-on delay");
endmodule // ohp_host_port_sva

bind ohp_host_port ohp_host_port_sva #(.ON_DELAY_CYCLES(ON_DELAY_CYCLES)) u_sva (
   .CLK_SYS(CLK_SYS), .NRST(NRST), .CLOCK_LINE_PIN(CLOCK_LINE_PIN), .HOST_PORT_SELECT(HOST_PORT_SELECT),
   .CMD_OR_PAYLOAD_FLAG(CMD_OR_PAYLOAD_FLAG), .CHIP_SELECT_N(CHIP_SELECT_N), .SERIAL_DATA_IN(SERIAL_DATA_IN),
   .I2C_OUT_LINE_O(I2C_OUT_LINE_O), .I2C_OUT_LINE_OE(I2C_OUT_LINE_OE), .FRAME_MEM_HOLD(FRAME_MEM_HOLD),
   .ROW_DRIVER_INDEX(ROW_DRIVER_INDEX), .COLUMN_DRIVER_OUTPUT(COLUMN_DRIVER_OUTPUT),
   .DRIVERS_ON(DRIVERS_ON), .SERIAL_OVERRUN(SERIAL_OVERRUN));

// *** ohp_host_model.sv ***
/*
 * Behavioural host driving the four-wire serial port and the two-wire port.
 * Assumes the bench calls send; the link clock stands still between bytes.
 */
`timescale 1ns/1ps
module ohp_host_model #(
   parameter int HALF_NS = 32
) (
   output logic clk_line,
   output logic cs_n,
   output logic sdi,
   output logic flag,
   input wire logic sda_pull
);
   // Idle levels before the first byte.
   initial begin
      clk_line = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
      flag = 1'b0;
   end
   // Sends one byte MSB first, holding the flag over all eight edges; released lines show inverted values.
   task automatic send(input logic dc, input logic [7:0] b);
      cs_n = 1'b0;
      flag = dc;
      for (int i = 7; i >= 0; i--) begin
         sdi = b[i];
         #(HALF_NS) clk_line = 1'b1;
         #(HALF_NS) clk_line = 1'b0;
      end
      cs_n = 1'b1;
      sdi = ~b[0];
      flag = ~dc;
      #(HALF_NS);
   endtask
   // Two-wire write of three bytes; ack records per byte whether the device pulled the data line low.
   task automatic i2c_wr(input logic strap, input logic [23:0] bytes, output logic [2:0] ack);
      flag = strap;
      sdi = 1'b1;
      clk_line = 1'b1;
      #(4 * HALF_NS) sdi = 1'b0;
      #(4 * HALF_NS) clk_line = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         #(2 * HALF_NS) sdi = bytes[i];
         #(2 * HALF_NS) clk_line = 1'b1;
         #(4 * HALF_NS) clk_line = 1'b0;
         if (i % 8 == 0) begin
            #(2 * HALF_NS) sdi = 1'b1;
            #(2 * HALF_NS) clk_line = 1'b1;
            ack[i / 8] = sda_pull;
            #(4 * HALF_NS) clk_line = 1'b0;
         end
      end
      #(2 * HALF_NS) sdi = 1'b0;
      #(2 * HALF_NS) clk_line = 1'b1;
      #(4 * HALF_NS) sdi = 1'b1;
      // The clock parks low so that the next serial byte starts with a clean rising edge.
      #(4 * HALF_NS) clk_line = 1'b0;
   endtask
endmodule // ohp_host_model

// *** tb_oled_host_port_frame_ram.sv ***
/*
 * Self-checking bench: serial traffic from a host model, a frame model in the bench, row sweeps compared.
 * Assumes the checker is bound to the design and the turn-on delay is shortened to 20 cycles.
 */
`timescale 1ns/1ps
module tb_oled_host_port_frame_ram;
   import ohp_pkg::*;
   localparam int ON_DLY = 20;
   logic clk_sys, nrst, sel, hold, clk_line, cs_n, sdi, flag, sda_o, sda_oe, drv_on, overrun;
   logic [5:0] row_idx;
   logic [2:0] ack;
   logic [FRAME_COLS-1:0] col_out;
   int errors, n_compared, m_col, m_page, m_start;
   logic [7:0] m_mem [FRAME_PAGES][FRAME_COLS];
   logic m_seg, m_scan;

   ohp_host_model host (.clk_line(clk_line), .cs_n(cs_n), .sdi(sdi), .flag(flag), .sda_pull(sda_oe));
   ohp_host_port #(.ON_DELAY_CYCLES(ON_DLY)) dut (
      .CLK_SYS(clk_sys), .NRST(nrst), .CLOCK_LINE_PIN(clk_line), .HOST_PORT_SELECT(sel),
      .CMD_OR_PAYLOAD_FLAG(flag), .CHIP_SELECT_N(cs_n), .SERIAL_DATA_IN(sdi), .I2C_OUT_LINE_O(sda_o),
      .I2C_OUT_LINE_OE(sda_oe), .FRAME_MEM_HOLD(hold), .ROW_DRIVER_INDEX(row_idx),
      .COLUMN_DRIVER_OUTPUT(col_out), .DRIVERS_ON(drv_on), .SERIAL_OVERRUN(overrun));

   // System clock at 40 MHz.
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Comparisons of single flags and of whole driver rows.
   task automatic cmp_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_row(input logic [FRAME_COLS-1:0] got, input logic [FRAME_COLS-1:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Pulses reset low for n cycles and returns the model to its defaults.
   task automatic rst(input int n);
      @(negedge clk_sys);
      nrst = 1'b0;
      repeat (n) @(negedge clk_sys);
      nrst = 1'b1;
      foreach (m_mem[p, c]) m_mem[p][c] = 8'h00;
      m_col = 0;
      m_page = 0;
      m_start = 0;
      m_seg = 1'b0;
      m_scan = 1'b0;
      repeat (4) @(negedge clk_sys);
   endtask

   // Byte senders: commands leave the frame model alone, data lands at the pointer.
   task automatic cmd(input logic [7:0] b);
      host.send(1'b0, b);
   endtask
   task automatic mdl(input logic [7:0] b);
      m_mem[m_page][m_col] = (m_page == LAST_PAGE) ? {1'b0, b[6:0]} : b;
      m_col = (m_col + 1) % FRAME_COLS;
   endtask
   task automatic wr(input logic [7:0] b);
      host.send(1'b1, b);
      mdl(b);
   endtask
   task automatic set_pos(input int p, input int c);
      cmd(8'hB0 + 8'(p));
      cmd({CMD_COL_LOW_HI, 4'(c)});
      cmd({CMD_COL_HIGH_HI, 3'(c >> 4)});
      m_page = p;
      m_col = c;
   endtask

   // Expected driver row for a row output index under the current mapping.
   function automatic logic [FRAME_COLS-1:0] exp_row(input int idx);
      logic [FRAME_COLS-1:0] r;
      int row;
      row = ((m_scan ? FRAME_ROWS - 1 - idx : idx) + m_start) % FRAME_ROWS;
      for (int j = 0; j < FRAME_COLS; j++)
         r[j] = m_mem[row / PAGE_ROWS][m_seg ? FRAME_COLS - 1 - j : j][row % PAGE_ROWS];
      return r;
   endfunction

   // Walks every row output and one random index past the last row.
   task automatic sweep(input logic on);
      for (int i = 0; i <= FRAME_ROWS; i++) begin
         @(negedge clk_sys);
         row_idx = (i == FRAME_ROWS) ? 6'(FRAME_ROWS + $urandom_range(24)) : 6'(i);
         repeat (2) @(negedge clk_sys);
         cmp_row(col_out, (on && i < FRAME_ROWS) ? exp_row(i) : '0);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic test_done();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Cuts a hang short well past the expected run length.
   initial begin
      #400_000;
      errors++;
      test_done();
   end

   // Main sequence.
   initial begin
      int v;
      nrst = 1'b0;
      sel = 1'b0;
      hold = 1'b0;
      row_idx = 6'h00;
      errors = 0;
      n_compared = 0;
      void'($urandom(32'h9758_c8ce));
      rst(4);
      cmp_bit(drv_on, 1'b0);
      cmp_bit(overrun, 1'b0);
      // Display on: drivers stay off through the delay, then come on.
      cmd(CMD_DISP_ON);
      repeat (ON_DLY - 2) @(negedge clk_sys);
      cmp_bit(drv_on, 1'b0);
      repeat (12) @(negedge clk_sys);
      cmp_bit(drv_on, 1'b1);
      // Data equal to a command code, random fills in every band, a column wrap in the last band.
      wr(CMD_DISP_OFF);
      for (int p = 0; p < FRAME_PAGES; p++) begin
         set_pos(p, $urandom_range(FRAME_COLS - 1));
         repeat (6) wr(8'($urandom));
      end
      set_pos(LAST_PAGE, FRAME_COLS - 2);
      repeat (4) wr(8'($urandom));
      // A byte sent while the other port is selected is discarded.
      @(negedge clk_sys);
      sel = 1'b1;
      repeat (4) @(negedge clk_sys);
      host.send(1'b1, 8'hFF);
      // Two-wire write: the strap picks the address, so the same address goes unanswered with the strap low.
      host.i2c_wr(1'b1, {I2C_ADDR_BASE, 2'b10, 8'h40, 8'hC3}, ack);
      cmp_bit(&ack, 1'b1);
      mdl(8'hC3);
      host.i2c_wr(1'b0, {I2C_ADDR_BASE, 2'b10, 8'h40, 8'h3C}, ack);
      cmp_bit(|ack, 1'b0);
      cmp_bit(sda_o, 1'b0);
      @(negedge clk_sys);
      sel = 1'b0;
      repeat (4) @(negedge clk_sys);
      wr(8'h5A);
      cmp_bit(drv_on, 1'b1);
      // Every remap combination with a start line, the last one out of range.
      for (int k = 0; k < 4; k++) begin
         v = (k == 3) ? 45 : $urandom_range(FRAME_ROWS - 1);
         cmd(k[0] ? CMD_SEG_REV : CMD_SEG_NORM);
         cmd(k[1] ? CMD_SCAN_REV : CMD_SCAN_NORM);
         cmd(CMD_START_LINE);
         cmd(8'(v));
         m_seg = k[0];
         m_scan = k[1];
         m_start = v % FRAME_ROWS;
         repeat (10) @(negedge clk_sys);
         sweep(1'b1);
      end
      // Stalled decoder: sixteen words fit, the next is dropped and flagged.
      set_pos(1, 0);
      repeat (10) @(negedge clk_sys);
      hold = 1'b1;
      for (int i = 0; i < FIFO_DEPTH; i++) wr(8'(i * 17 + 1));
      repeat (10) @(negedge clk_sys);
      cmp_bit(overrun, 1'b0);
      host.send(1'b1, 8'hEE);
      repeat (10) @(negedge clk_sys);
      cmp_bit(overrun, 1'b1);
      hold = 1'b0;
      repeat (30) @(negedge clk_sys);
      cmp_bit(overrun, 1'b1);
      sweep(1'b1);
      // Display off blanks every row.
      cmd(CMD_DISP_OFF);
      repeat (10) @(negedge clk_sys);
      cmp_bit(drv_on, 1'b0);
      sweep(1'b0);
      // Long init pulse clears the flag, the memory and the mapping.
      rst(120);
      cmp_bit(overrun, 1'b0);
      cmp_bit(drv_on, 1'b0);
      cmd(CMD_DISP_ON);
      repeat (ON_DLY + 12) @(negedge clk_sys);
      sweep(1'b1);
      test_done();
   end
endmodule // tb_oled_host_port_frame_ram
